/* File: fbo_pkg.sv */
// fbo_pkg: offsets, field positions, reset values and types shared by the
// flash bank operation control block and its sequencer.
// assumes a byte-addressed register port with one 32-bit word per register.
package fbo_pkg;

    localparam int DATA_W = 16;

    // register byte offsets
    localparam logic [7:0] OFS_BANK_KEY = 8'h04;
    localparam logic [7:0] OFS_CFG_KEY = 8'h08;
    localparam logic [7:0] OFS_STATUS = 8'h0C;
    localparam logic [7:0] OFS_CONTROL = 8'h10;
    localparam logic [7:0] OFS_TARGET = 8'h14;
    localparam logic [7:0] OFS_PROG_DATA = 8'h18;

    // status field positions
    localparam int STS_BUSY = 0;
    localparam int STS_PROG_ERR = 2;
    localparam int STS_PROT_ERR = 4;
    localparam int STS_DONE = 5;

    // control field positions
    localparam int CTL_WORD_PROG = 0;
    localparam int CTL_SECT_ERS = 1;
    localparam int CTL_BANK_ERS = 2;
    localparam int CTL_CFG_PROG = 4;
    localparam int CTL_CFG_ERS = 5;
    localparam int CTL_ERASE_START = 6;
    localparam int CTL_OP_LOCK = 7;
    localparam int CTL_CFG_UNLK = 9;
    localparam int CTL_ERR_IE = 10;
    localparam int CTL_DONE_IE = 12;

    localparam logic [31:0] STS_RESET = 32'h0000_0000;
    localparam logic [31:0] CTL_RESET = 32'h0000_0080;
    localparam logic [31:0] READ_ZERO = 32'h0000_0000;
    localparam logic [DATA_W-1:0] ERASED_WORD = 16'hFFFF;

    typedef enum logic [2:0] {
        FBO_OP_NONE = 3'h0,
        FBO_OP_WORD_PROG = 3'h1,
        FBO_OP_SECT_ERS = 3'h2,
        FBO_OP_BANK_ERS = 3'h3,
        FBO_OP_CFG_PROG = 3'h4,
        FBO_OP_CFG_ERS = 3'h5
    } fbo_op_t;

    typedef enum logic [2:0] {
        FBO_ST_IDLE = 3'b001,
        FBO_ST_CHECK = 3'b010,
        FBO_ST_WAIT = 3'b100
    } fbo_state_t;

    // protection is kept per pair of sectors
    function automatic logic [4:0] fbo_prot_index(input logic [31:0] addr,
                                                  input int shift);
        logic [31:0] pair;
        pair = addr >> (shift + 1);
        return pair[4:0];
    endfunction : fbo_prot_index

endpackage : fbo_pkg

/* File: fbo_op_if.sv */
// fbo_op_if: operation request and result between register logic and the
// sequencer; all signals on clk_sys.
`timescale 1ns/1ps
interface fbo_op_if;
    import fbo_pkg::*;
    logic start;
    fbo_op_t kind;
    logic [31:0] addr;
    logic [DATA_W-1:0] wdata;
    logic main_locked;
    logic cfg_unlocked;
    logic busy;
    logic done;
    logic prot_err;
    logic prog_err;
    logic ended;
    modport ctl (output start, kind, addr, wdata, main_locked, cfg_unlocked,
                 input busy, done, prot_err, prog_err, ended);
    modport seq (input start, kind, addr, wdata, main_locked, cfg_unlocked,
                 output busy, done, prot_err, prog_err, ended);
endinterface : fbo_op_if

/* File: fbo_key_unlock.sv */
// fbo_key_unlock: two-word key sequence checker, one pulse per good pair.
// assumes key writes arrive as one-cycle strobes on clk_sys.
`timescale 1ns/1ps
module fbo_key_unlock #(
    parameter logic [31:0] KEY_FIRST = 32'h1234_5678,
    parameter logic [31:0] KEY_SECOND = 32'h8765_4321
) (
    // clock and reset
    input wire logic clk_sys,
    input wire logic rst,
    // key write
    input wire logic key_wr,
    input wire logic [31:0] key_data,
    // result
    output logic unlock_pulse
);
    logic armed;
    logic next_armed;
    logic next_unlock_pulse;

    // any wrong word drops the sequence back to its start
    always_comb begin
        next_armed = armed;
        next_unlock_pulse = 1'b0;
        if (key_wr) begin
            if (armed && key_data == KEY_SECOND) begin
                next_unlock_pulse = 1'b1;
                next_armed = 1'b0;
            end else begin
                next_armed = (key_data == KEY_FIRST);
            end
        end
    end

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            armed <= 1'b0;
            unlock_pulse <= 1'b0;
        end else begin
            armed <= next_armed;
            unlock_pulse <= next_unlock_pulse;
        end
    end
endmodule : fbo_key_unlock

/* File: fbo_op_seq.sv */
// fbo_op_seq: checks lock, protection and erased state, then hands one
// operation to the flash array and waits for its done.
// assumes array_rdata is valid one cycle after array_addr changes.
`timescale 1ns/1ps
module fbo_op_seq #(
    parameter int SECTOR_SHIFT = 11
) (
    // clock and reset
    input wire logic clk_sys,
    input wire logic rst,
    // request from register logic
    fbo_op_if.seq op,
    // protection state of the loaded configuration, 1 = protected
    input wire logic [31:0] protect_status,
    // flash array
    output logic array_req,
    output fbo_pkg::fbo_op_t array_op,
    output logic [31:0] array_addr,
    output logic [fbo_pkg::DATA_W-1:0] array_wdata,
    input wire logic [fbo_pkg::DATA_W-1:0] array_rdata,
    input wire logic array_done
);
    import fbo_pkg::*;

    fbo_state_t state, next_state;
    fbo_op_t next_op;
    logic [31:0] next_addr;
    logic [DATA_W-1:0] next_wdata;
    logic next_req, next_done, next_prot, next_prog, next_ended;
    logic is_prog, is_cfg, locked, prot_hit;

    // refusal checks made in the check state
    always_comb begin
        is_prog = (array_op == FBO_OP_WORD_PROG) ||
                  (array_op == FBO_OP_CFG_PROG);
        is_cfg = (array_op == FBO_OP_CFG_PROG) ||
                 (array_op == FBO_OP_CFG_ERS);
        locked = is_cfg ? !op.cfg_unlocked : op.main_locked;
        unique case (array_op)
            FBO_OP_WORD_PROG,
            FBO_OP_SECT_ERS: prot_hit = protect_status[
                fbo_prot_index(array_addr, SECTOR_SHIFT)];
            FBO_OP_BANK_ERS: prot_hit = |protect_status;
            default: prot_hit = 1'b0;
        endcase
    end

    // next state and one-cycle results
    always_comb begin
        next_state = state;
        next_op = array_op;
        next_addr = array_addr;
        next_wdata = array_wdata;
        next_req = 1'b0;
        next_done = 1'b0;
        next_prot = 1'b0;
        next_prog = 1'b0;
        next_ended = 1'b0;
        unique case (state)
            FBO_ST_IDLE: begin
                if (op.start) begin
                    next_op = op.kind;
                    next_addr = op.addr;
                    next_wdata = op.wdata;
                    next_state = FBO_ST_CHECK;
                end
            end
            FBO_ST_CHECK: begin
                if (locked || prot_hit) begin
                    next_prot = 1'b1;
                    next_ended = 1'b1;
                    next_state = FBO_ST_IDLE;
                end else if (is_prog && array_rdata != ERASED_WORD) begin
                    next_prog = 1'b1;
                    next_ended = 1'b1;
                    next_state = FBO_ST_IDLE;
                end else begin
                    next_req = 1'b1;
                    next_state = FBO_ST_WAIT;
                end
            end
            FBO_ST_WAIT: begin
                if (array_done) begin
                    next_done = 1'b1;
                    next_ended = 1'b1;
                    next_state = FBO_ST_IDLE;
                end
            end
        endcase
    end

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            state <= FBO_ST_IDLE;
            array_op <= FBO_OP_NONE;
            array_addr <= 32'h0000_0000;
            array_wdata <= ERASED_WORD;
            array_req <= 1'b0;
            op.done <= 1'b0;
            op.prot_err <= 1'b0;
            op.prog_err <= 1'b0;
            op.ended <= 1'b0;
        end else begin
            state <= next_state;
            array_op <= next_op;
            array_addr <= next_addr;
            array_wdata <= next_wdata;
            array_req <= next_req;
            op.done <= next_done;
            op.prot_err <= next_prot;
            op.prog_err <= next_prog;
            op.ended <= next_ended;
        end
    end

    assign op.busy = (state != FBO_ST_IDLE);
endmodule : fbo_op_seq

/* File: fbo_bank_ctrl.sv */
// fbo_bank_ctrl: register file, unlock handling, operation launch and
// interrupt for one flash bank.
// assumes a same-clock register master and a same-clock flash array.
//
// How it works
// - the config-area key register is 32-bit, write-only and reads zero.
// - writing the key words to it asks to unlock the configuration area.
// - done is set when a program or erase completes, cleared by writing one.
// - a program to a protected address sets prot error; write 1 clears.
// - a program to a word that is not erased sets program error; 1 clears.
// - the busy flag is read-only and high while an operation runs.
// - the done interrupt enable gates the done flag and resets to zero.
// - the error interrupt enable gates both error flags.
// - a good config unlock sets the unlocked bit; writing zero clears it.
// - op lock resets to one, a good bank unlock clears it, a one sets it.
// - erase start launches the selected erase and clears itself when done.
// - reserved bits read zero and ignore writes.
// - the bank key register takes the bank unlock words and reads zero.
// - the low control bits select the kind of operation.
// - a protected sector or bank refuses the operation and flags an error.
//
// The strobed register port and the placing of the registers were left to the implementer.
`timescale 1ns/1ps
module fbo_bank_ctrl #(
    parameter int SECTOR_SHIFT = 11,
    parameter logic [31:0] BANK_KEY_FIRST = 32'h1234_5678,
    parameter logic [31:0] BANK_KEY_SECOND = 32'h8765_4321,
    parameter logic [31:0] CFG_KEY_FIRST = 32'h1234_5678,
    parameter logic [31:0] CFG_KEY_SECOND = 32'h8765_4321
) (
    // clock and reset
    input wire logic clk_sys,
    input wire logic rst,
    // register port
    input wire logic [7:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [31:0] reg_rdata,
    // protection state, 1 = pair of sectors protected
    input wire logic [31:0] protect_status,
    // flash array
    output logic array_req,
    output fbo_pkg::fbo_op_t array_op,
    output logic [31:0] array_addr,
    output logic [fbo_pkg::DATA_W-1:0] array_wdata,
    input wire logic [fbo_pkg::DATA_W-1:0] array_rdata,
    input wire logic array_done,
    // interrupt
    output logic irq
);
    import fbo_pkg::*;

    // protection index must stay inside a 32-bit address
    if (SECTOR_SHIFT < 0 || SECTOR_SHIFT > 26) begin : g_bad_shift
        $error("fbo_bank_ctrl: SECTOR_SHIFT out of range");
    end

    fbo_op_if op ();

    // status flags
    logic done_flag, prot_flag, prog_flag;
    logic next_done_flag, next_prot_flag, next_prog_flag;
    // control bits
    logic sel_word, sel_sect, sel_bank, sel_cfgp, sel_cfge;
    logic next_sel_word, next_sel_sect, next_sel_bank;
    logic next_sel_cfgp, next_sel_cfge;
    logic erase_start, next_erase_start;
    logic op_lock, next_op_lock;
    logic cfg_unlk, next_cfg_unlk;
    logic err_ie, next_err_ie;
    logic done_ie, next_done_ie;
    logic [31:0] target, next_target;
    // launch
    logic start, next_start;
    fbo_op_t kind, next_kind;
    logic [DATA_W-1:0] wdata, next_wdata;
    // read port and interrupt
    logic [31:0] next_rdata;
    logic next_irq;
    // decodes
    logic wr_sts, wr_ctl, wr_tgt, wr_prog, wr_bkey, wr_ckey;
    logic bank_unlock, cfg_unlock, busy_any;
    logic [31:0] sts_word, ctl_word;

    // address decode; a launch pending counts as busy
    always_comb begin
        wr_sts = reg_wr && reg_addr == OFS_STATUS;
        wr_ctl = reg_wr && reg_addr == OFS_CONTROL;
        wr_tgt = reg_wr && reg_addr == OFS_TARGET;
        wr_prog = reg_wr && reg_addr == OFS_PROG_DATA;
        wr_bkey = reg_wr && reg_addr == OFS_BANK_KEY;
        // the configuration key only counts once the bank is open
        wr_ckey = reg_wr && reg_addr == OFS_CFG_KEY && !op_lock;
        busy_any = op.busy || start;
    end

    // key sequence checkers, one per unlockable area
    fbo_key_unlock #(
        .KEY_FIRST(BANK_KEY_FIRST),
        .KEY_SECOND(BANK_KEY_SECOND)
    ) u_bank_key (
        .clk_sys(clk_sys),
        .rst(rst),
        .key_wr(wr_bkey),
        .key_data(reg_wdata),
        .unlock_pulse(bank_unlock)
    );

    fbo_key_unlock #(
        .KEY_FIRST(CFG_KEY_FIRST),
        .KEY_SECOND(CFG_KEY_SECOND)
    ) u_cfg_key (
        .clk_sys(clk_sys),
        .rst(rst),
        .key_wr(wr_ckey),
        .key_data(reg_wdata),
        .unlock_pulse(cfg_unlock)
    );

    // sticky status flags: a hardware set in the clearing cycle wins
    always_comb begin
        next_done_flag = (done_flag && !(wr_sts && reg_wdata[STS_DONE]))
                         || op.done;
        next_prot_flag = (prot_flag && !(wr_sts && reg_wdata[STS_PROT_ERR]))
                         || op.prot_err;
        next_prog_flag = (prog_flag && !(wr_sts && reg_wdata[STS_PROG_ERR]))
                         || op.prog_err;
    end

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            done_flag <= STS_RESET[STS_DONE];
            prot_flag <= STS_RESET[STS_PROT_ERR];
            prog_flag <= STS_RESET[STS_PROG_ERR];
        end else begin
            done_flag <= next_done_flag;
            prot_flag <= next_prot_flag;
            prog_flag <= next_prog_flag;
        end
    end

    // control register, target address and operation launch
    always_comb begin
        next_sel_word = sel_word;
        next_sel_sect = sel_sect;
        next_sel_bank = sel_bank;
        next_sel_cfgp = sel_cfgp;
        next_sel_cfge = sel_cfge;
        next_erase_start = erase_start;
        next_op_lock = op_lock;
        next_cfg_unlk = cfg_unlk;
        next_err_ie = err_ie;
        next_done_ie = done_ie;
        next_target = target;
        next_start = 1'b0;
        next_kind = kind;
        next_wdata = wdata;
        if (wr_tgt) begin
            next_target = reg_wdata;
        end
        if (wr_ctl) begin
            // only documented fields are stored; the rest stay zero
            next_sel_word = reg_wdata[CTL_WORD_PROG];
            next_sel_sect = reg_wdata[CTL_SECT_ERS];
            next_sel_bank = reg_wdata[CTL_BANK_ERS];
            next_sel_cfgp = reg_wdata[CTL_CFG_PROG];
            next_sel_cfge = reg_wdata[CTL_CFG_ERS];
            next_err_ie = reg_wdata[CTL_ERR_IE];
            next_done_ie = reg_wdata[CTL_DONE_IE];
            if (reg_wdata[CTL_OP_LOCK]) begin
                next_op_lock = 1'b1;
            end
            if (!reg_wdata[CTL_CFG_UNLK]) begin
                next_cfg_unlk = 1'b0;
            end
            // erase launch uses the selects written in the same word
            if (reg_wdata[CTL_ERASE_START] && !erase_start && !busy_any) begin
                if (reg_wdata[CTL_SECT_ERS]) begin
                    next_kind = FBO_OP_SECT_ERS;
                    next_start = 1'b1;
                end else if (reg_wdata[CTL_BANK_ERS]) begin
                    next_kind = FBO_OP_BANK_ERS;
                    next_start = 1'b1;
                end else if (reg_wdata[CTL_CFG_ERS]) begin
                    next_kind = FBO_OP_CFG_ERS;
                    next_start = 1'b1;
                end
                next_erase_start = next_start;
            end
        end
        // a data write with a program select starts a program
        if (wr_prog && !busy_any && !erase_start) begin
            if (sel_word) begin
                next_kind = FBO_OP_WORD_PROG;
                next_start = 1'b1;
            end else if (sel_cfgp) begin
                next_kind = FBO_OP_CFG_PROG;
                next_start = 1'b1;
            end
            next_wdata = reg_wdata[DATA_W-1:0];
        end
        // erase start falls when its erase finishes or is refused
        if (op.ended && erase_start) begin
            next_erase_start = 1'b0;
        end
        // hardware unlocks win over a software write in the same cycle
        if (bank_unlock) begin
            next_op_lock = 1'b0;
        end
        if (cfg_unlock) begin
            next_cfg_unlk = 1'b1;
        end
    end

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            sel_word <= CTL_RESET[CTL_WORD_PROG];
            sel_sect <= CTL_RESET[CTL_SECT_ERS];
            sel_bank <= CTL_RESET[CTL_BANK_ERS];
            sel_cfgp <= CTL_RESET[CTL_CFG_PROG];
            sel_cfge <= CTL_RESET[CTL_CFG_ERS];
            erase_start <= CTL_RESET[CTL_ERASE_START];
            op_lock <= CTL_RESET[CTL_OP_LOCK];
            cfg_unlk <= CTL_RESET[CTL_CFG_UNLK];
            err_ie <= CTL_RESET[CTL_ERR_IE];
            done_ie <= CTL_RESET[CTL_DONE_IE];
            target <= 32'h0000_0000;
            start <= 1'b0;
            kind <= FBO_OP_NONE;
            wdata <= ERASED_WORD;
        end else begin
            sel_word <= next_sel_word;
            sel_sect <= next_sel_sect;
            sel_bank <= next_sel_bank;
            sel_cfgp <= next_sel_cfgp;
            sel_cfge <= next_sel_cfge;
            erase_start <= next_erase_start;
            op_lock <= next_op_lock;
            cfg_unlk <= next_cfg_unlk;
            err_ie <= next_err_ie;
            done_ie <= next_done_ie;
            target <= next_target;
            start <= next_start;
            kind <= next_kind;
            wdata <= next_wdata;
        end
    end

    // request towards the sequencer
    assign op.start = start;
    assign op.kind = kind;
    assign op.addr = target;
    assign op.wdata = wdata;
    assign op.main_locked = op_lock;
    assign op.cfg_unlocked = cfg_unlk;

    fbo_op_seq #(
        .SECTOR_SHIFT(SECTOR_SHIFT)
    ) u_seq (
        .clk_sys(clk_sys),
        .rst(rst),
        .op(op),
        .protect_status(protect_status),
        .array_req(array_req),
        .array_op(array_op),
        .array_addr(array_addr),
        .array_wdata(array_wdata),
        .array_rdata(array_rdata),
        .array_done(array_done)
    );

    // read words; unused positions stay zero
    always_comb begin
        sts_word = READ_ZERO;
        sts_word[STS_BUSY] = busy_any;
        sts_word[STS_PROG_ERR] = prog_flag;
        sts_word[STS_PROT_ERR] = prot_flag;
        sts_word[STS_DONE] = done_flag;
        ctl_word = READ_ZERO;
        ctl_word[CTL_WORD_PROG] = sel_word;
        ctl_word[CTL_SECT_ERS] = sel_sect;
        ctl_word[CTL_BANK_ERS] = sel_bank;
        ctl_word[CTL_CFG_PROG] = sel_cfgp;
        ctl_word[CTL_CFG_ERS] = sel_cfge;
        ctl_word[CTL_ERASE_START] = erase_start;
        ctl_word[CTL_OP_LOCK] = op_lock;
        ctl_word[CTL_CFG_UNLK] = cfg_unlk;
        ctl_word[CTL_ERR_IE] = err_ie;
        ctl_word[CTL_DONE_IE] = done_ie;
    end

    // read data stands one cycle, zero otherwise; key, target and program
    // data words are write-only and read as zero
    always_comb begin
        next_rdata = READ_ZERO;
        if (reg_rd) begin
            unique case (reg_addr)
                OFS_STATUS: next_rdata = sts_word;
                OFS_CONTROL: next_rdata = ctl_word;
                default: next_rdata = READ_ZERO;
            endcase
        end
        next_irq = (done_flag && done_ie) ||
                   ((prot_flag || prog_flag) && err_ie);
    end

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            reg_rdata <= READ_ZERO;
            irq <= 1'b0;
        end else begin
            reg_rdata <= next_rdata;
            irq <= next_irq;
        end
    end
endmodule : fbo_bank_ctrl

/* File: fbo_bank_ctrl_monitor.sv */
// fbo_bank_ctrl_monitor: port-level checks of the flash bank control block.
// assumes a bind onto fbo_bank_ctrl with SECTOR_SHIFT handed on.
`timescale 1ns/1ps
module fbo_bank_ctrl_monitor #(
    parameter int SECTOR_SHIFT = 11
) (
    // clock and reset
    input wire logic clk_sys,
    input wire logic rst,
    // register port
    input wire logic [7:0] reg_addr,
    input wire logic reg_rd,
    input wire logic [31:0] reg_rdata,
    // protection and array
    input wire logic [31:0] protect_status,
    input wire logic array_req,
    input wire fbo_pkg::fbo_op_t array_op,
    input wire logic [31:0] array_addr,
    input wire logic [fbo_pkg::DATA_W-1:0] array_rdata
);
    import fbo_pkg::*;
    logic [31:0] pair;
    // sector pair of the launched address; only the low five bits matter
    assign pair = array_addr >> (SECTOR_SHIFT + 1);
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (rst);
    a_cfg_key_zero: assert property (
        reg_rd && reg_addr == OFS_CFG_KEY |=> reg_rdata == READ_ZERO)
        else $error("config key read not zero");
    a_bank_key_zero: assert property (
        reg_rd && reg_addr == OFS_BANK_KEY |=> reg_rdata == READ_ZERO)
        else $error("bank key read not zero");
    a_sts_rsvd_zero: assert property (
        reg_rd && reg_addr == OFS_STATUS |=> !(reg_rdata & 32'hFFFF_FFCA))
        else $error("status reserved bit set");
    a_ctl_rsvd_zero: assert property (
        reg_rd && reg_addr == OFS_CONTROL |=> !(reg_rdata & 32'hFFFF_E908))
        else $error("control reserved bit set");
    a_sect_prot_ok: assert property (
        array_req && array_op inside {FBO_OP_WORD_PROG, FBO_OP_SECT_ERS}
        |-> !protect_status[pair[4:0]]) else $error("protected launch");
    a_bank_prot_ok: assert property (
        array_req && array_op == FBO_OP_BANK_ERS |-> protect_status == 0)
        else $error("bank erase under protection");
    a_prog_erased: assert property (
        array_req && array_op == FBO_OP_WORD_PROG
        |-> $past(array_rdata) == ERASED_WORD) else $error("program on data");
    a_req_single: assert property (
        array_req |=> !array_req [*3]) else $error("array request repeated");
endmodule : fbo_bank_ctrl_monitor

/* File: fbo_bank_ctrl_tb.sv */
// fbo_bank_ctrl_tb: register-level tests of the flash bank control block.
// assumes the array answers two cycles after each request.
`timescale 1ns/1ps
`define CHK(a, e) begin checked++; if ((a) !== (e)) begin num_errors++; \
    $display("ERROR %0t got %h want %h", $time, a, e); end end
module fbo_bank_ctrl_tb;
    import fbo_pkg::*;
    localparam logic [31:0] K1 = 32'hA5A5_0001;
    localparam logic [31:0] K2 = 32'h5A5A_0002;
    localparam logic [31:0] A = 32'h0000_3000;
    logic clk_sys = 1'h0, rst = 1'h1, reg_wr = 1'h0, reg_rd = 1'h0;
    logic [7:0] reg_addr = 8'h00;
    logic [31:0] reg_wdata = 32'h0, protect_status = 32'h0;
    logic [31:0] reg_rdata, array_addr;
    logic array_req, irq, d1 = 1'h0, array_done = 1'h0;
    logic [DATA_W-1:0] array_wdata, array_rdata = ERASED_WORD;
    fbo_op_t array_op;
    logic [31:0] ew [3] = '{32'h1642, 32'h1644, 32'h1660};
    fbo_op_t eo [3] = '{FBO_OP_SECT_ERS, FBO_OP_BANK_ERS, FBO_OP_CFG_ERS};
    int num_errors = 0, checked = 0;
    fbo_bank_ctrl #(.BANK_KEY_FIRST(K1), .BANK_KEY_SECOND(K2),
        .CFG_KEY_FIRST(K1), .CFG_KEY_SECOND(K2)) fbo_bank_ctrl_i (
        .clk_sys(clk_sys), .rst(rst), .reg_addr(reg_addr), .reg_rd(reg_rd),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rdata(reg_rdata),
        .protect_status(protect_status), .array_req(array_req),
        .array_op(array_op), .array_addr(array_addr), .irq(irq),
        .array_wdata(array_wdata), .array_rdata(array_rdata),
        .array_done(array_done));
    always #2.5 clk_sys = ~clk_sys;
    // array stand-in: a short fixed delay keeps busy windows readable
    always @(posedge clk_sys) begin
        d1 <= array_req;
        array_done <= d1;
    end
    task wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk_sys);
        reg_wr <= 1'h1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge clk_sys);
        reg_wr <= 1'h0;
    endtask : wr
    // read data stands only in the cycle after the strobe edge
    task rd(input logic [7:0] a, input logic [31:0] e, input bit c = 1);
        @(posedge clk_sys);
        reg_rd <= 1'h1;
        reg_addr <= a;
        @(posedge clk_sys);
        reg_rd <= 1'h0;
        #1;
        if (c) `CHK(reg_rdata, e)
    endtask : rd
    // poll busy under a bound, then check, clear and recheck the flags
    task chk_clr(input logic [31:0] e, input logic q);
        int n;
        n = 0;
        do begin
            rd(OFS_STATUS, 0, 0);
            n++;
        end while (reg_rdata[STS_BUSY] !== 1'h0 && n < 40);
        `CHK(n < 40, 1'h1)
        rd(OFS_STATUS, e);
        `CHK(irq, q)
        wr(OFS_STATUS, e);
        rd(OFS_STATUS, STS_RESET);
        `CHK(irq, 1'h0)
        $display("test step done at %0t", $time);
    endtask : chk_clr
    task pg(input logic [31:0] c, input logic [31:0] e, input logic q);
        wr(OFS_CONTROL, c);
        wr(OFS_PROG_DATA, 32'h0000_BEEF);
        chk_clr(e, q);
    endtask : pg
    task final_report;
        $display("checked %0d num_errors %0d", checked, num_errors);
        if (num_errors == 0 && checked > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask : final_report
    initial begin
        repeat (4) @(posedge clk_sys);
        rst <= 1'h0;
        rd(OFS_STATUS, STS_RESET);
        rd(OFS_CONTROL, CTL_RESET);
        wr(OFS_CFG_KEY, 32'h0);
        rd(OFS_CFG_KEY, READ_ZERO);
        wr(8'h40, 32'hFFFF_FFFF);
        rd(8'h40, READ_ZERO);
        pg(32'h0000_0042, 32'h0000_0010, 1'h0);
        wr(OFS_BANK_KEY, K1);
        wr(OFS_BANK_KEY, K2);
        // the sector select written with the refused erase is still stored
        rd(OFS_CONTROL, 32'h0000_0002);
        rd(OFS_BANK_KEY, READ_ZERO);
        wr(OFS_CONTROL, 32'hFFFF_FD08);
        rd(OFS_CONTROL, 32'h0000_1400);
        wr(OFS_CFG_KEY, K1);
        wr(OFS_CFG_KEY, K2);
        rd(OFS_CONTROL, 32'h0000_1600);
        wr(OFS_TARGET, A);
        foreach (ew[i]) begin
            wr(OFS_CONTROL, ew[i]);
            rd(OFS_CONTROL, ew[i]);
            chk_clr(32'h0000_0020, 1'h1);
            rd(OFS_CONTROL, ew[i] & ~32'h40);
            `CHK(array_op, eo[i])
            `CHK(array_addr, A)
        end
        pg(32'h0000_1610, 32'h0000_0020, 1'h1);
        `CHK(array_op, FBO_OP_CFG_PROG)
        pg(32'h0000_1601, 32'h0000_0020, 1'h1);
        `CHK(array_wdata, 16'hBEEF)
        array_rdata <= 16'h1234;
        pg(32'h0000_1601, 32'h0000_0004, 1'h1);
        pg(32'h0000_1201, 32'h0000_0004, 1'h0);
        array_rdata <= ERASED_WORD;
        pg(32'h0000_0601, 32'h0000_0020, 1'h0);
        protect_status <= 32'h0000_0008;
        pg(32'h0000_1601, 32'h0000_0010, 1'h1);
        pg(32'h0000_1644, 32'h0000_0010, 1'h1);
        protect_status <= 32'h0;
        wr(OFS_CONTROL, 32'h0000_1400);
        rd(OFS_CONTROL, 32'h0000_1400);
        pg(32'h0000_1460, 32'h0000_0010, 1'h1);
        wr(OFS_CONTROL, 32'h0000_0080);
        rd(OFS_CONTROL, 32'h0000_0080);
        pg(32'h0000_0081, 32'h0000_0010, 1'h0);
        final_report();
    end
    // watchdog well past the few hundred cycles the tests need
    initial begin
        #50000;
        num_errors++;
        final_report();
    end
endmodule : fbo_bank_ctrl_tb
bind fbo_bank_ctrl fbo_bank_ctrl_monitor #(.SECTOR_SHIFT(SECTOR_SHIFT)) mon_i (
    .clk_sys(clk_sys), .rst(rst), .reg_addr(reg_addr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .protect_status(protect_status),
    .array_req(array_req), .array_op(array_op), .array_addr(array_addr),
    .array_rdata(array_rdata));
